// ---- logic/lsc_top.sv ----
// Configuration register for the main loop synthesiser
//
// Behaviour
// - Oscillator equals reference times multiplier over divider
// - Output divider bits 17:16, code 00 divides two
// - Peripheral divider bits 27:24, codes 0,1 error
// - Input divider bits 5:0, codes 0,1 error
// - Input divider writable only with main, audio off
// - Multiplier bits 14:6, valid 50 to 432
// - Bit 22 picks internal RC or external clock
// - Reference bit writable only with both loops off
// - Register at 0x04, reset 0x2400_3010
// - Byte, halfword, word access without wait
// - Low-power entry clears main loop enable
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module lsc_top (
  input wire logic core_clk, // 50 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [lsc_pkg::ADDR_W-1:0] bus_addr, // Byte address
  input wire logic [31:0] bus_wdata, // Write data
  input wire logic [3:0] bus_be, // Byte lanes of a write
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [31:0] bus_rdata, // Read data, cycle after strobe
  input wire logic main_loop_enable, // Main loop enable bit
  input wire logic second_loop_enable, // Second loop enable bit
  input wire logic audio_loop_enable, // Audio loop enable bit
  input wire logic lowpower_entry, // Pulse on standby or stop entry
  output logic main_loop_enable_clr, // Clear pulse for main enable
  output logic [5:0] vco_input_divider, // Input divider code
  output logic [8:0] vco_feedback_multiplier, // Multiplier code
  output logic [1:0] main_output_divider, // Output divider code
  output logic [3:0] main_output_ratio, // Output division factor
  output logic [3:0] peripheral_clock_divider, // Peripheral divider
  output logic loop_reference_select, // 0 internal RC, 1 external
  output logic factor_error, // Some factor code is illegal
  output logic config_valid // All factor codes legal
);
  import lsc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic clr_q;
  logic [3:0] ratio_q;
  logic [3:0] ratio_d;
  logic in_err_q;
  logic mul_err_q;
  logic per_err_q;
  logic ferr_q;
  logic valid_q;

  ////////////////////////////////////////////////////////////////////
  // Address decode
  wire hit_cfg;
  wire hit_stat;
  wire cfg_wr;
  assign hit_cfg = (bus_addr[7:2] == CFG_OFF[7:2]);
  assign hit_stat = (bus_addr[7:2] == STAT_OFF[7:2]);
  assign cfg_wr = bus_wr && hit_cfg;

  ////////////////////////////////////////////////////////////////////
  // Write locks
  // The enable bit is gone the same cycle low-power entry hits, so a
  // write in that cycle already counts the main loop as stopped
  wire main_on;
  wire in_lock;
  wire ref_lock;
  assign main_on = main_loop_enable && !lowpower_entry;
  assign in_lock = main_on || audio_loop_enable;
  assign ref_lock = main_on || second_loop_enable;

  ////////////////////////////////////////////////////////////////////
  // Write merge by byte lane, writable field and lock
  wire [31:0] be_mask;
  wire [31:0] in_mask;
  wire [31:0] ref_mask;
  wire [31:0] lock_mask;
  wire [31:0] wr_mask;
  assign be_mask = {{8{bus_be[3]}}, {8{bus_be[2]}}, {8{bus_be[1]}}, {8{bus_be[0]}}};
  assign in_mask = {{(32-IN_W){1'b0}}, {IN_W{1'b1}}} << IN_LSB;
  assign ref_mask = 32'h0000_0001 << REF_BIT;
  assign lock_mask = (in_lock ? in_mask : 32'h0) | (ref_lock ? ref_mask : 32'h0);
  assign wr_mask = be_mask & WR_MASK & ~lock_mask;
  assign cfg_d = cfg_wr ? ((cfg_q & ~wr_mask) | (bus_wdata & wr_mask)) : cfg_q;

  // Factor register; reserved bits are never stored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CFG_RST & WR_MASK;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field views
  wire [IN_W-1:0] in_f;
  wire [MUL_W-1:0] mul_f;
  wire [OUT_W-1:0] out_f;
  wire [PER_W-1:0] per_f;
  assign in_f = cfg_q[IN_LSB +: IN_W];
  assign mul_f = cfg_q[MUL_LSB +: MUL_W];
  assign out_f = cfg_q[OUT_LSB +: OUT_W];
  assign per_f = cfg_q[PER_LSB +: PER_W];

  ////////////////////////////////////////////////////////////////////
  // Range checks, one small checker per factor except the output divider
  lsc_range_if #(.W(IN_W)) in_rng ();
  lsc_range_if #(.W(MUL_W)) mul_rng ();
  lsc_range_if #(.W(PER_W)) per_rng ();
  assign in_rng.value = in_f;
  assign mul_rng.value = mul_f;
  assign per_rng.value = per_f;

  lsc_range_chk #(.W(IN_W), .LO(IN_MIN), .HI(IN_MAX)) u_in_chk (
    .rng(in_rng)
  );
  lsc_range_chk #(.W(MUL_W), .LO(MUL_MIN), .HI(MUL_MAX)) u_mul_chk (
    .rng(mul_rng)
  );
  lsc_range_chk #(.W(PER_W), .LO(PER_MIN), .HI(PER_MAX)) u_per_chk (
    .rng(per_rng)
  );

  ////////////////////////////////////////////////////////////////////
  // Output divider ratio: code n divides by 2*(n+1)
  assign ratio_d = {1'b0, out_f, 1'b0} + OUT_RATIO_BASE;

  // Derived values lag the register by one cycle so outputs are flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ratio_q <= OUT_RATIO_BASE;
      in_err_q <= 1'b0;
      mul_err_q <= 1'b0;
      per_err_q <= 1'b0;
      ferr_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      in_err_q <= in_rng.err;
      mul_err_q <= mul_rng.err;
      per_err_q <= per_rng.err;
      ferr_q <= in_rng.err || mul_rng.err || per_rng.err;
      valid_q <= !(in_rng.err || mul_rng.err || per_rng.err);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Low-power entry clears the neighbouring main enable bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= lowpower_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  wire [31:0] stat_word;
  wire [31:0] cfg_word;
  assign cfg_word = cfg_q | RSV_RD;
  assign stat_word = {26'h0, valid_q, ref_lock, in_lock, per_err_q, mul_err_q, in_err_q};
  assign rdata_d = !bus_rd ? 32'h0 :
                   hit_cfg ? cfg_word :
                   hit_stat ? stat_word : 32'h0;

  // Data stand only in the cycle after the strobe, never a wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus_rdata = rdata_q;
  assign main_loop_enable_clr = clr_q;
  assign vco_input_divider = in_f;
  assign vco_feedback_multiplier = mul_f;
  assign main_output_divider = out_f;
  assign main_output_ratio = ratio_q;
  assign peripheral_clock_divider = per_f;
  assign loop_reference_select = cfg_q[REF_BIT];
  assign factor_error = ferr_q;
  assign config_valid = valid_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_in_locked;
    cfg_wr && in_lock |=> $stable(vco_input_divider);
  endproperty
  a_in_locked: assert property (p_in_locked)
    else $error("input divider changed while locked");

  property p_ref_locked;
    cfg_wr && ref_lock |=> $stable(loop_reference_select);
  endproperty
  a_ref_locked: assert property (p_ref_locked)
    else $error("reference select changed while locked");

  property p_in_write;
    cfg_wr && !in_lock && bus_be[0] |=> vco_input_divider == $past(bus_wdata[5:0]);
  endproperty
  a_in_write: assert property (p_in_write)
    else $error("unlocked input divider write lost");

  property p_ref_write;
    cfg_wr && !ref_lock && bus_be[2]
      |=> loop_reference_select == $past(bus_wdata[22]);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("unlocked reference write lost");

  property p_in_err;
    ##1 in_err_q == ($past(vco_input_divider) < 6'h02);
  endproperty
  a_in_err: assert property (p_in_err)
    else $error("input divider error flag wrong");

  property p_mul_err;
    ##1 mul_err_q == ($past(vco_feedback_multiplier) < 9'h032
                      || $past(vco_feedback_multiplier) > 9'h1B0);
  endproperty
  a_mul_err: assert property (p_mul_err)
    else $error("multiplier error flag wrong");

  property p_per_err;
    ##1 per_err_q == ($past(peripheral_clock_divider) < 4'h2);
  endproperty
  a_per_err: assert property (p_per_err)
    else $error("peripheral divider error flag wrong");

  property p_ratio;
    $stable(main_output_divider) [*2] |-> main_output_ratio == 
      {1'b0, main_output_divider, 1'b0} + 4'h2;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("output divider ratio wrong");

  property p_read_cfg;
    bus_rd && hit_cfg |=> bus_rdata == ($past(cfg_q) | 32'h2000_0000) ##1 bus_rdata == 32'h0
      || $past(bus_rd);
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("factor register read wrong");

  property p_lowpower;
    lowpower_entry |=> main_loop_enable_clr;
  endproperty
  a_lowpower: assert property (p_lowpower)
    else $error("main enable clear missing");

  property p_rsv;
    (cfg_q & ~WR_MASK) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bit stored");

  property p_hold;
    !cfg_wr |=> $stable(cfg_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("factor register changed without a write");

  property p_mul_write;
    cfg_wr && bus_be[1] && bus_be[0] |=> vco_feedback_multiplier == $past(bus_wdata[14:6]);
  endproperty
  a_mul_write: assert property (p_mul_write)
    else $error("multiplier write lost");

  property p_per_write;
    cfg_wr && bus_be[3] |=> peripheral_clock_divider == $past(bus_wdata[27:24]);
  endproperty
  a_per_write: assert property (p_per_write)
    else $error("peripheral divider write lost");

  property p_rdata_idle;
    !bus_rd |=> bus_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the read slot");

  property p_clr_pulse;
    !lowpower_entry |=> !main_loop_enable_clr;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("spurious main enable clear");

  // Main scenarios
  c_locked_write: cover property (cfg_wr && in_lock);
  c_unlocked_write: cover property (cfg_wr && !in_lock && !ref_lock);
  c_lowpower_unlock: cover property (main_loop_enable && lowpower_entry && cfg_wr);
  c_bad_factor: cover property (!factor_error ##1 factor_error);
  c_status_read: cover property (bus_rd && hit_stat);
endmodule : lsc_top
`default_nettype wire

// ---- shared/lsc_pkg.sv ----
// Shared constants for the loop synthesiser configuration block
`default_nettype none
package lsc_pkg;
  // Register offsets and bus widths
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h0C;

  // Factor register reset value and writable bits
  localparam logic [31:0] CFG_RST = 32'h2400_3010;
  localparam logic [31:0] WR_MASK = 32'h0F43_7FFF;
  localparam logic [31:0] RSV_RD = CFG_RST & ~WR_MASK;

  // Field positions and widths
  localparam int IN_LSB = 0;
  localparam int IN_W = 6;
  localparam int MUL_LSB = 6;
  localparam int MUL_W = 9;
  localparam int OUT_LSB = 16;
  localparam int OUT_W = 2;
  localparam int REF_BIT = 22;
  localparam int PER_LSB = 24;
  localparam int PER_W = 4;

  // Valid factor ranges
  localparam int IN_MIN = 2;
  localparam int IN_MAX = 63;
  localparam int MUL_MIN = 50;
  localparam int MUL_MAX = 432;
  localparam int PER_MIN = 2;
  localparam int PER_MAX = 15;

  // Status register bit positions
  localparam int ST_IN_ERR = 0;
  localparam int ST_MUL_ERR = 1;
  localparam int ST_PER_ERR = 2;
  localparam int ST_IN_LOCK = 3;
  localparam int ST_REF_LOCK = 4;
  localparam int ST_VALID = 5;

  // Fixed offset of the main output divider ratio
  localparam logic [3:0] OUT_RATIO_BASE = 4'h2;
endpackage : lsc_pkg
`default_nettype wire

// ---- shared/lsc_range_if.sv ----
// Carrier between the factor register and one range checker
`timescale 1ns/1ns
`default_nettype none
interface lsc_range_if #(parameter int W = 6);
  logic [W-1:0] value; // Factor code under test
  logic err; // Code lies outside its valid range
  modport chk (input value, output err);
  modport user (output value, input err);
endinterface : lsc_range_if
`default_nettype wire

// ---- logic/lsc_range_chk.sv ----
// Range checker for one factor code
`timescale 1ns/1ns
`default_nettype none
module lsc_range_chk #(
  parameter int W = 6,
  parameter int LO = 2,
  parameter int HI = 63
) (
  lsc_range_if.chk rng // Code in, error out
);
  // Widen to 32 bits so the bounds compare without truncation
  wire [31:0] val_ext;
  assign val_ext = {{(32-W){1'b0}}, rng.value};
  assign rng.err = (val_ext < LO) || (val_ext > HI);
endmodule : lsc_range_chk
`default_nettype wire

// ---- verification/test_lsc_top.sv ----
// Self-checking bench for the loop synthesiser configuration register
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module test_lsc_top;
  import lsc_pkg::*;
  logic core_clk, nrst, bus_wr, bus_rd, lowpower_entry, clr, refsel, ferr, cvalid;
  logic main_loop_enable, second_loop_enable, audio_loop_enable;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, model_q;
  logic [3:0] bus_be, ratio, per;
  logic [5:0] ind;
  logic [8:0] mul;
  logic [1:0] outd;
  int n_fail = 0;
  int tests_run = 0;

  lsc_top lsc_top_inst (.core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .main_loop_enable(main_loop_enable),
    .second_loop_enable(second_loop_enable), .audio_loop_enable(audio_loop_enable),
    .lowpower_entry(lowpower_entry), .main_loop_enable_clr(clr),
    .vco_input_divider(ind), .vco_feedback_multiplier(mul), .main_output_divider(outd),
    .main_output_ratio(ratio), .peripheral_clock_divider(per),
    .loop_reference_select(refsel), .factor_error(ferr), .config_valid(cvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and verdict
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Run needs a few hundred cycles; 2000 leaves ample margin
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end

  task automatic print_verdict();
    $display("Checks run %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks; model updated with enables as the design samples them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                    input logic lp);
    logic [31:0] m;
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= be;
    lowpower_entry <= lp;
    @(posedge core_clk);
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WR_MASK;
    if ((main_loop_enable & !lp) | audio_loop_enable) m[5:0] = 6'h00;
    if ((main_loop_enable & !lp) | second_loop_enable) m[22] = 1'b0;
    if (a == CFG_OFF) model_q = (model_q & ~m) | (d & m);
    bus_wr <= 1'b0;
    lowpower_entry <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 `CHK(bus_rdata, e)
    @(posedge core_clk);
    #1 `CHK(bus_rdata, 32'h0000_0000)
  endtask : rd

  // Compares every field output, flags and both registers against the model
  task automatic chk_cfg();
    logic ie, me, pe;
    logic [31:0] st;
    ie = model_q[5:0] < IN_MIN;
    me = model_q[14:6] < MUL_MIN || model_q[14:6] > MUL_MAX;
    pe = model_q[27:24] < PER_MIN;
    st = 32'h0000_0000;
    st[ST_IN_ERR] = ie;
    st[ST_MUL_ERR] = me;
    st[ST_PER_ERR] = pe;
    st[ST_IN_LOCK] = main_loop_enable | audio_loop_enable;
    st[ST_REF_LOCK] = main_loop_enable | second_loop_enable;
    st[ST_VALID] = !(ie | me | pe);
    @(posedge core_clk);
    #1 `CHK(ind, model_q[5:0])
    `CHK(mul, model_q[14:6])
    `CHK(outd, model_q[17:16])
    `CHK(ratio, 4'({model_q[17:16], 1'b0}) + 4'h2)
    `CHK(per, model_q[27:24])
    `CHK(refsel, model_q[22])
    `CHK(ferr, ie | me | pe)
    `CHK(cvalid, !(ie | me | pe))
    rd(CFG_OFF, model_q);
    rd(STAT_OFF, st);
  endtask : chk_cfg

  function automatic logic [31:0] mk(int i, int m, int o, int p, int r);
    mk = {4'h0, 4'(p), 1'b0, 1'(r), 4'h0, 2'(o), 1'b0, 9'(m), 6'(i)};
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] tbl [7];
    tbl = '{mk(1, 50, 0, 2, 0), mk(2, 49, 1, 2, 1), mk(63, 432, 2, 15, 0),
      mk(2, 433, 3, 2, 1), mk(2, 50, 0, 1, 0), mk(0, 51, 1, 0, 1), mk(3, 431, 2, 3, 0)};
    {nrst, bus_wr, bus_rd, lowpower_entry, bus_addr, bus_wdata, bus_be} = '0;
    {main_loop_enable, second_loop_enable, audio_loop_enable} = 3'b000;
    model_q = CFG_RST;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    chk_cfg();
    rd(8'h10, 32'h0000_0000);
    wr(CFG_OFF, 32'hFFFF_FFFF, 4'hF, 1'b0);
    chk_cfg();
    // Range edges and every output divider code
    foreach (tbl[k]) begin
      wr(CFG_OFF, tbl[k], 4'hF, 1'b0);
      chk_cfg();
    end
    // Every mix of running loops against both write locks
    for (int k = 1; k < 8; k++) begin
      @(posedge core_clk);
      {main_loop_enable, second_loop_enable, audio_loop_enable} <= 3'(k);
      wr(CFG_OFF, model_q ^ 32'h0040_0015, 4'hF, 1'b0);
      chk_cfg();
    end
    // Low-power entry frees the locks held by the main loop alone
    @(posedge core_clk);
    {main_loop_enable, second_loop_enable, audio_loop_enable} <= 3'b100;
    wr(CFG_OFF, model_q ^ 32'h0040_0015, 4'hF, 1'b1);
    #1 `CHK(clr, 1'b1)
    chk_cfg();
    `CHK(clr, 1'b0)
    @(posedge core_clk);
    main_loop_enable <= 1'b0;
    // Byte and halfword lanes, status writes ignored
    wr(CFG_OFF, 32'hFFFF_FF03, 4'h1, 1'b0);
    chk_cfg();
    wr(CFG_OFF, 32'h0A00_0000, 4'hC, 1'b0);
    chk_cfg();
    wr(STAT_OFF, 32'hFFFF_FFFF, 4'hF, 1'b0);
    chk_cfg();
    // Reset in mid-run must bring back the reset word, not keep writes
    @(posedge core_clk);
    nrst <= 1'b0;
    #1 `CHK(cvalid, 1'b0)
    `CHK(per, CFG_RST[27:24])
    @(posedge core_clk);
    nrst <= 1'b1;
    model_q = CFG_RST;
    chk_cfg();
    print_verdict();
  end
endmodule : test_lsc_top
`default_nettype wire
